// File: core/mmd_decoder.sv
// mmd_decoder: address decoder and low-page i/o registers
// assumes: ahb-lite master, external eprom/rom answers mem_rdata
// combinationally from mem_addr, pins arrive asynchronously
`timescale 1ns/1ns
`default_nettype none

module mmd_decoder #(
    parameter int RAM_DEPTH = mmd_pkg::RAM_WORDS
) (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // external eprom and rom arrays
    output logic [12:0]      mem_addr,
    output logic [2:0]       mem_region,
    input  wire logic [7:0]  mem_rdata,
    // watchdog
    output logic             watchdog_timer_clear,
    // stack pointer steps from the cpu core
    input  wire logic        sp_push,
    input  wire logic        sp_pop,
    output logic [7:0]       stack_ptr,
    // port pins
    input  wire logic [7:0]  port_a_in,
    output logic [7:0]       port_a_out,
    output logic [7:0]       port_a_oe,
    input  wire logic [2:0]  port_b_in,
    output logic [2:0]       port_b_out,
    output logic [2:0]       port_b_oe,
    input  wire logic [7:0]  port_c_in,
    output logic [7:0]       port_c_out,
    output logic [7:0]       port_c_oe,
    input  wire logic [1:0]  port_d_in,
    output logic             port_d_out,
    output logic             port_d_oe,
    // serial port core
    output logic             serial_port_enable,
    output logic             serial_port_master,
    output logic [7:0]       serial_port_data,
    output logic             serial_port_data_wr,
    input  wire logic [1:0]  serial_port_flags
);

    // synchroniser stage set for one port: three flops plus filtered value
    typedef struct packed {
        logic [7:0] s1;
        logic [7:0] s2;
        logic [7:0] s3;
        logic [7:0] f;
    } mmd_sync_s;

    typedef struct packed {
        mmd_pkg::mmd_bus_e    bus;
        logic [12:0]          addr;
        mmd_pkg::mmd_region_e region;
        logic [7:0]           rdata;
        logic [7:0]           pa;
        logic [2:0]           pb;
        logic [7:0]           pc;
        logic                 pd;
        logic [7:0]           dir_a;
        logic [2:0]           dir_b;
        logic [7:0]           dir_c;
        logic                 dir_d;
        logic                 ser_en;
        logic                 ser_ms;
        logic [7:0]           ser_dat;
        logic                 ser_wr;
        logic [5:0]           sp;
        logic                 wdog;
        mmd_sync_s            sy_a;
        mmd_sync_s            sy_b;
        mmd_sync_s            sy_c;
        mmd_sync_s            sy_d;
    } mmd_state_s;

    mmd_state_s st_r;
    mmd_state_s st_nxt;

    logic [7:0] ram_r [RAM_DEPTH];
    logic       ram_we;
    logic [7:0] ram_idx;
    logic [7:0] ram_rd;

    // one decoder for all modes, no mode input is needed
    function automatic mmd_pkg::mmd_region_e decode(input logic [12:0] a);
        mmd_pkg::mmd_region_e r;
        r = mmd_pkg::RG_NONE;
        if (a <= mmd_pkg::IO_HI)
            r = mmd_pkg::RG_IO;
        else if (a >= mmd_pkg::PZ_LO && a <= mmd_pkg::PZ_HI)
            r = mmd_pkg::RG_PZ;
        else if (a >= mmd_pkg::RAM_LO && a <= mmd_pkg::RAM_HI)
            r = mmd_pkg::RG_RAM;
        else if (a >= mmd_pkg::EP_LO && a <= mmd_pkg::EP_HI)
            r = mmd_pkg::RG_EP;
        else if (a >= mmd_pkg::BOOT_LO && a <= mmd_pkg::BOOT_HI)
            r = mmd_pkg::RG_BOOT;
        else if (a >= mmd_pkg::VEC_LO)
            r = mmd_pkg::RG_VEC;
        return r;
    endfunction : decode

    // pin read: output bits show the latch, input bits the pin
    function automatic logic [7:0] pin_mix(
        input logic [7:0] lat,
        input logic [7:0] dir,
        input logic [7:0] pin
    );
        return (lat & dir) | (pin & ~dir);
    endfunction : pin_mix

    // next synchroniser stage; filtered bit sets when s2 and s3 are both one, holds when both are zero, clears when they differ
    function automatic mmd_sync_s sync_step(
        input mmd_sync_s  s,
        input logic [7:0] pin
    );
        mmd_sync_s n;
        n.s1 = pin;
        n.s2 = s.s1;
        n.s3 = s.s2;
        n.f  = (s.s2 & s.s3) | (s.f & ~(s.s2 ^ s.s3));
        return n;
    endfunction : sync_step

    // i/o page read mux
    function automatic logic [7:0] io_read(
        input mmd_state_s s,
        input logic [4:0] o,
        input logic [1:0] flg
    );
        logic [7:0] v;
        v = mmd_pkg::UNDEF_BYTE;
        case (o)
            mmd_pkg::OFS_PA_PINS:
                v = pin_mix(s.pa, s.dir_a, s.sy_a.f);
            mmd_pkg::OFS_PB_PINS:
                v = pin_mix({s.pb, 5'h00}, {s.dir_b, 5'h00},
                            s.sy_b.f);
            mmd_pkg::OFS_PC_PINS:
                v = pin_mix(s.pc, s.dir_c, s.sy_c.f);
            mmd_pkg::OFS_PD_PINS:
            begin
                v = 8'h00;
                v[mmd_pkg::PD_IN_BIT] = s.sy_d.f[1];
                v[mmd_pkg::PD_IO_BIT] = s.dir_d ? s.pd
                                                : s.sy_d.f[0];
            end
            mmd_pkg::OFS_PA_DIR:  v = s.dir_a;
            mmd_pkg::OFS_PB_DIR:
                v = {s.dir_b, mmd_pkg::PB_DIR_ONES};
            mmd_pkg::OFS_PC_DIR:  v = s.dir_c;
            mmd_pkg::OFS_PD_DIR:
            begin
                v = 8'h00;
                v[mmd_pkg::PD_IO_BIT] = s.dir_d;
            end
            mmd_pkg::OFS_SER_CTL:
            begin
                v = 8'h00;
                v[mmd_pkg::SER_EN_BIT] = s.ser_en;
                v[mmd_pkg::SER_MS_BIT] = s.ser_ms;
            end
            mmd_pkg::OFS_SER_FLG: v = {flg, 6'h00};
            mmd_pkg::OFS_SER_DAT: v = s.ser_dat;
            default:              v = mmd_pkg::UNDEF_BYTE;
        endcase
        return v;
    endfunction : io_read

    // ram addressing relative to the region base
    always_comb
    begin
        ram_idx = 8'(st_r.addr - mmd_pkg::RAM_LO);
        ram_rd  = ram_r[ram_idx];
    end

    // next-state logic: bus fsm, register writes, pins, stack pointer
    always_comb
    begin
        logic        take;
        logic [12:0] a;
        logic [7:0]  wd;
        take = 1'b0;
        a    = 13'h0000;
        wd   = 8'h00;
        st_nxt = st_r;
        ram_we = 1'b0;
        st_nxt.wdog   = 1'b0;
        st_nxt.ser_wr = 1'b0;
        st_nxt.sy_a = sync_step(st_r.sy_a, port_a_in);
        st_nxt.sy_b = sync_step(st_r.sy_b, {port_b_in, 5'h00});
        st_nxt.sy_c = sync_step(st_r.sy_c, port_c_in);
        st_nxt.sy_d = sync_step(st_r.sy_d, {6'h00, port_d_in});
        // stack pointer keeps its six low bits, so it wraps in 64 bytes
        if (sp_push && !sp_pop)
            st_nxt.sp = st_r.sp - 6'h01;
        else if (sp_pop && !sp_push)
            st_nxt.sp = st_r.sp + 6'h01;
        wd = hwdata[7:0];
        // data phase work of the previous address phase
        case (st_r.bus)
            mmd_pkg::BS_WR:
            begin
                if (st_r.region == mmd_pkg::RG_IO)
                begin
                    case (st_r.addr[4:0])
                        mmd_pkg::OFS_PA_PINS: st_nxt.pa = wd;
                        mmd_pkg::OFS_PB_PINS: st_nxt.pb = wd[7:5];
                        mmd_pkg::OFS_PC_PINS: st_nxt.pc = wd;
                        mmd_pkg::OFS_PD_PINS:
                            st_nxt.pd = wd[mmd_pkg::PD_IO_BIT];
                        mmd_pkg::OFS_PA_DIR:  st_nxt.dir_a = wd;
                        mmd_pkg::OFS_PB_DIR:
                            st_nxt.dir_b = wd[7:5];
                        mmd_pkg::OFS_PC_DIR:  st_nxt.dir_c = wd;
                        mmd_pkg::OFS_PD_DIR:
                            st_nxt.dir_d = wd[mmd_pkg::PD_IO_BIT];
                        mmd_pkg::OFS_SER_CTL:
                        begin
                            st_nxt.ser_en = wd[mmd_pkg::SER_EN_BIT];
                            st_nxt.ser_ms = wd[mmd_pkg::SER_MS_BIT];
                        end
                        mmd_pkg::OFS_SER_DAT:
                        begin
                            st_nxt.ser_dat = wd;
                            st_nxt.ser_wr  = 1'b1;
                        end
                        default: st_nxt.pa = st_r.pa;
                    endcase
                end
                if (st_r.region == mmd_pkg::RG_RAM)
                    ram_we = 1'b1;
                if (st_r.addr == mmd_pkg::WDOG_ADDR &&
                    !wd[mmd_pkg::WDOG_BIT])
                    st_nxt.wdog = 1'b1;
                st_nxt.bus = mmd_pkg::BS_IDLE;
            end
            mmd_pkg::BS_RD:
            begin
                case (st_r.region)
                    mmd_pkg::RG_IO:
                        st_nxt.rdata = io_read(st_r, st_r.addr[4:0],
                                               serial_port_flags);
                    mmd_pkg::RG_RAM:  st_nxt.rdata = ram_rd;
                    mmd_pkg::RG_PZ,
                    mmd_pkg::RG_EP,
                    mmd_pkg::RG_BOOT,
                    mmd_pkg::RG_VEC:
                        st_nxt.rdata = mem_rdata;
                    default:
                        st_nxt.rdata = mmd_pkg::UNDEF_BYTE;
                endcase
                st_nxt.bus = mmd_pkg::BS_RDY;
            end
            mmd_pkg::BS_RDY:  st_nxt.bus = mmd_pkg::BS_IDLE;
            default:          st_nxt.bus = mmd_pkg::BS_IDLE;
        endcase
        // address phase, accepted when hsel, htrans[1] and hready are high and the slave is ready
        take = hsel && htrans[1] && hready &&
               (st_r.bus != mmd_pkg::BS_RD);
        if (take)
        begin
            a = haddr[mmd_pkg::AW_MSB:mmd_pkg::AW_LSB];
            st_nxt.addr   = a;
            st_nxt.region = (haddr[31:mmd_pkg::AW_MSB + 1] == '0)
                            ? decode(a) : mmd_pkg::RG_NONE;
            st_nxt.bus    = hwrite ? mmd_pkg::BS_WR : mmd_pkg::BS_RD;
            if (haddr[31:mmd_pkg::AW_MSB + 1] != '0)
                st_nxt.addr = 13'h0000;
        end
    end

    // state register; port data latches keep their value over reset
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_r.bus     <= mmd_pkg::BS_IDLE;
            st_r.addr    <= 13'h0000;
            st_r.region  <= mmd_pkg::RG_NONE;
            st_r.rdata   <= mmd_pkg::UNDEF_BYTE;
            st_r.dir_a   <= mmd_pkg::DIR8_RST;
            st_r.dir_b   <= mmd_pkg::DIR3_RST;
            st_r.dir_c   <= mmd_pkg::DIR8_RST;
            st_r.dir_d   <= 1'b0;
            st_r.ser_en  <= 1'b0;
            st_r.ser_ms  <= 1'b0;
            st_r.ser_dat <= 8'h00;
            st_r.ser_wr  <= 1'b0;
            st_r.sp      <= mmd_pkg::SP_RST;
            st_r.wdog    <= 1'b0;
            st_r.sy_a    <= '0;
            st_r.sy_b    <= '0;
            st_r.sy_c    <= '0;
            st_r.sy_d    <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ram array, no reset
    always_ff @(posedge hclk)
    begin
        if (ram_we)
            ram_r[ram_idx] <= hwdata[7:0];
    end

    // bus answer: one wait state on reads, none on writes
    assign hreadyout = (st_r.bus != mmd_pkg::BS_RD);
    assign hresp     = 1'b0;
    assign hrdata    = {24'h000000, st_r.rdata};

    // external arrays see the registered address and region
    assign mem_addr   = st_r.addr;
    assign mem_region = st_r.region;

    // side outputs
    assign watchdog_timer_clear = st_r.wdog;
    assign stack_ptr            = {mmd_pkg::SP_TOP, st_r.sp};
    assign port_a_out           = st_r.pa;
    assign port_a_oe            = st_r.dir_a;
    assign port_b_out           = st_r.pb;
    assign port_b_oe            = st_r.dir_b;
    assign port_c_out           = st_r.pc;
    assign port_c_oe            = st_r.dir_c;
    assign port_d_out           = st_r.pd;
    assign port_d_oe            = st_r.dir_d;
    assign serial_port_enable   = st_r.ser_en;
    assign serial_port_master   = st_r.ser_ms;
    assign serial_port_data     = st_r.ser_dat;
    assign serial_port_data_wr  = st_r.ser_wr;

endmodule : mmd_decoder

`default_nettype wire

// File: core/mmd_pkg.sv
// mmd_pkg: constants and types for the memory map decoder
// assumes: 13-bit cpu addresses, one cpu word at each aligned bus word
package mmd_pkg;

    // region bounds of the 8 kbyte space
    localparam logic [12:0] IO_LO   = 13'h0000;
    localparam logic [12:0] IO_HI   = 13'h001f;
    localparam logic [12:0] PZ_LO   = 13'h0020;
    localparam logic [12:0] PZ_HI   = 13'h004f;
    localparam logic [12:0] RAM_LO  = 13'h0050;
    localparam logic [12:0] RAM_HI  = 13'h00ff;
    localparam logic [12:0] EP_LO   = 13'h0100;
    localparam logic [12:0] EP_HI   = 13'h12ff;
    localparam logic [12:0] BOOT_LO = 13'h1f01;
    localparam logic [12:0] BOOT_HI = 13'h1fef;
    localparam logic [12:0] VEC_LO  = 13'h1ff0;
    localparam logic [12:0] VEC_HI  = 13'h1fff;
    localparam logic [12:0] WDOG_ADDR = 13'h1ff0;
    localparam int          RAM_WORDS = 176;

    // register indices in the i/o page (byte address is four times these)
    localparam logic [4:0] OFS_PA_PINS = 5'h00;
    localparam logic [4:0] OFS_PB_PINS = 5'h01;
    localparam logic [4:0] OFS_PC_PINS = 5'h02;
    localparam logic [4:0] OFS_PD_PINS = 5'h03;
    localparam logic [4:0] OFS_PA_DIR  = 5'h04;
    localparam logic [4:0] OFS_PB_DIR  = 5'h05;
    localparam logic [4:0] OFS_PC_DIR  = 5'h06;
    localparam logic [4:0] OFS_PD_DIR  = 5'h07;
    localparam logic [4:0] OFS_SER_CTL = 5'h0a;
    localparam logic [4:0] OFS_SER_FLG = 5'h0b;
    localparam logic [4:0] OFS_SER_DAT = 5'h0c;

    // field positions
    localparam int WDOG_BIT   = 0;
    localparam int SER_EN_BIT = 6;
    localparam int SER_MS_BIT = 4;
    localparam int PD_IN_BIT  = 7;
    localparam int PD_IO_BIT  = 5;

    // reset and fixed read values
    localparam logic [7:0] DIR8_RST    = 8'h00;
    localparam logic [2:0] DIR3_RST    = 3'h0;
    localparam logic [5:0] SP_RST      = 6'h3f;
    localparam logic [1:0] SP_TOP      = 2'h3;
    localparam logic [4:0] PB_DIR_ONES = 5'h1f;
    localparam logic [7:0] UNDEF_BYTE  = 8'h00;

    // bus address layout
    localparam int AW_LSB = 2;
    localparam int AW_MSB = 14;

    typedef enum logic [2:0] {
        RG_NONE = 3'b000,
        RG_IO   = 3'b001,
        RG_PZ   = 3'b010,
        RG_RAM  = 3'b011,
        RG_EP   = 3'b100,
        RG_BOOT = 3'b101,
        RG_VEC  = 3'b110
    } mmd_region_e;

    typedef enum logic [1:0] {
        BS_IDLE = 2'b00,
        BS_WR   = 2'b01,
        BS_RD   = 2'b10,
        BS_RDY  = 2'b11
    } mmd_bus_e;

endpackage : mmd_pkg

// File: verif/mmd_mem_model.sv
// mmd_mem_model: eprom, page-zero and boot rom arrays behind the decoder
// assumes: read-only arrays answering at once from mem_addr
`timescale 1ns/1ns
`default_nettype none
module mmd_mem_model (
    // array access
    input  wire logic [12:0] mem_addr,
    input  wire logic [2:0]  mem_region,
    output logic [7:0]       mem_rdata
);
    // selected arrays give a fixed pattern; otherwise the model drives the inverted low address byte
    always_comb
    begin
        if (mem_region == 3'h2 || mem_region >= 3'h4)
            mem_rdata = mem_addr[7:0] ^ mem_addr[12:5] ^ 8'h5a;
        else
            mem_rdata = ~mem_addr[7:0];
    end
endmodule : mmd_mem_model
`default_nettype wire

// File: verif/mmd_decoder_checker.sv
// mmd_decoder_checker: bus, decode, watchdog and stack assertions
// assumes: hready is tied to hreadyout by the bench
`timescale 1ns/1ns
`default_nettype none
module mmd_decoder_checker (
    // bus
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    // decode and side outputs
    input wire logic [12:0] mem_addr,
    input wire logic [2:0]  mem_region,
    input wire logic        watchdog_timer_clear,
    input wire logic        sp_push,
    input wire logic        sp_pop,
    input wire logic [7:0]  stack_ptr
);
    logic        tk;
    logic [12:0] ca;
    logic [2:0]  rg;
    // accepted transfer and the region it ought to select
    assign tk = hsel & htrans[1] & hready & hreadyout;
    assign ca = haddr[14:2];
    assign rg = (haddr[31:15] != 17'h0) ? 3'h0
              : (ca <= mmd_pkg::IO_HI) ? 3'h1
              : (ca <= mmd_pkg::PZ_HI) ? 3'h2
              : (ca <= mmd_pkg::RAM_HI) ? 3'h3
              : (ca <= mmd_pkg::EP_HI) ? 3'h4
              : (ca < mmd_pkg::BOOT_LO) ? 3'h0
              : (ca <= mmd_pkg::BOOT_HI) ? 3'h5 : 3'h6;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_write_nowait: assert property (tk && hwrite |=> hreadyout)
        else $error("write data phase stalled");
    a_read_wait: assert property (tk && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read data phase not two cycles");
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("error response seen");
    a_region_map: assert property (tk |=> mem_region == $past(rg))
        else $error("wrong region selected");
    a_addr_latch: assert property (tk |=> mem_addr == $past(ca))
        else $error("array address not taken");
    a_wdog_pulse: assert property (tk && hwrite && rg == 3'h6 &&
        ca == mmd_pkg::WDOG_ADDR ##1 !hwdata[0] |=> watchdog_timer_clear)
        else $error("watchdog clear missing");
    a_wdog_hold: assert property (tk && hwrite && rg == 3'h6 &&
        ca == mmd_pkg::WDOG_ADDR ##1 hwdata[0] |=> !watchdog_timer_clear)
        else $error("watchdog cleared by a one");
    a_sp_push: assert property (sp_push && !sp_pop |=> stack_ptr ==
        ($past(stack_ptr) == 8'hc0 ? 8'hff : $past(stack_ptr) - 8'h01))
        else $error("push step wrong");
    a_sp_pop: assert property (sp_pop && !sp_push |=> stack_ptr ==
        ($past(stack_ptr) == 8'hff ? 8'hc0 : $past(stack_ptr) + 8'h01))
        else $error("pop step wrong");
    a_sp_range: assert property (stack_ptr[7:6] == 2'b11)
        else $error("stack pointer out of window");
    a_rdata_high: assert property (hrdata[31:8] == 24'h0)
        else $error("upper read data not zero");
endmodule : mmd_decoder_checker

bind mmd_decoder mmd_decoder_checker chk (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .hrdata,
    .mem_addr, .mem_region, .watchdog_timer_clear, .sp_push, .sp_pop,
    .stack_ptr);
`default_nettype wire

// File: verif/mmd_decoder_test.sv
// mmd_decoder_test: register, map, stack and watchdog tests
// assumes: mmd_mem_model stands for the arrays; one ahb-lite master
`timescale 1ns/1ns
`default_nettype none
module mmd_decoder_test;
    logic hclk, hresetn, hsel, hwrite, hresp, hreadyout, sp_push, sp_pop;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans, port_d_in, serial_port_flags;
    logic [2:0]  hsize, mem_region, port_b_in, port_b_out, port_b_oe;
    logic [12:0] mem_addr;
    logic [7:0]  mem_rdata, stack_ptr, port_a_in, port_a_out, port_a_oe;
    logic [7:0]  port_c_in, port_c_out, port_c_oe, serial_port_data;
    logic        port_d_out, port_d_oe, watchdog_timer_clear;
    logic        serial_port_enable, serial_port_master, serial_port_data_wr;
    wire logic   hready;
    int          bad_count, samples_checked, wd_n, sd_n;
    logic [7:0]  q;
    logic [7:0]  dr[4] = '{8'h00, 8'h1f, 8'h00, 8'h00};
    logic [7:0]  pr[4] = '{8'h3c, 8'ha0, 8'h81, 8'h80};
    logic [7:0]  pw[4] = '{8'ha5, 8'hff, 8'h5a, 8'hff};
    logic [7:0]  pb[4] = '{8'ha5, 8'he0, 8'h5a, 8'ha0};
    logic [7:0]  db[4] = '{8'hff, 8'hff, 8'hff, 8'h20};
    logic [12:0] ra[14] = '{13'h0, 13'h1f, 13'h20, 13'h4f, 13'h50, 13'hff,
        13'h100, 13'h12ff, 13'h1300, 13'h1f00, 13'h1f01, 13'h1fef, 13'h1ff0,
        13'h1fff};
    logic [2:0]  rr[14] = '{1, 1, 2, 2, 3, 3, 4, 4, 0, 0, 5, 5, 6, 6};

    assign hready = hreadyout;
    mmd_decoder uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready, .hreadyout, .hresp, .hrdata, .mem_addr, .mem_region,
        .mem_rdata, .watchdog_timer_clear, .sp_push, .sp_pop, .stack_ptr,
        .port_a_in, .port_a_out, .port_a_oe, .port_b_in, .port_b_out,
        .port_b_oe, .port_c_in, .port_c_out, .port_c_oe, .port_d_in,
        .port_d_out, .port_d_oe, .serial_port_enable, .serial_port_master,
        .serial_port_data, .serial_port_data_wr, .serial_port_flags);
    mmd_mem_model mem (.mem_addr, .mem_region, .mem_rdata);

    // clock and watchdog pulse count
    always #50 hclk = ~hclk;
    always @(posedge hclk)
    begin
        if (watchdog_timer_clear === 1'b1)
            wd_n++;
        if (serial_port_data_wr === 1'b1)
            sd_n++;
    end

    function automatic logic [7:0] pat(input logic [12:0] a);
        return a[7:0] ^ a[12:5] ^ 8'h5a;
    endfunction : pat

    task automatic check(input string nm, input logic [7:0] got,
                         input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask : check

    // one single transfer: address phase, then data phase
    task automatic xfer(input logic w, input logic [31:0] ba,
                        input logic [7:0] d, output logic [7:0] r);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr  <= ba;
        hsize  <= 3'h2;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        do @(posedge hclk); while (hready !== 1'b1);
        r = hrdata[7:0];
    endtask : xfer

    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        logic [7:0] r;
        xfer(1'b1, {17'h0, a, 2'b00}, d, r);
    endtask : wr

    task automatic rc(input logic [12:0] a, input logic [7:0] e);
        logic [7:0] r;
        xfer(1'b0, {17'h0, a, 2'b00}, 8'h00, r);
        check($sformatf("addr %h", a), r, e);
    endtask : rc

    task automatic sp(input logic pu, input logic [7:0] e);
        sp_push <= pu;
        sp_pop  <= !pu;
        @(posedge hclk);
        sp_push <= 1'b0;
        sp_pop  <= 1'b0;
        @(posedge hclk);
        check("stack_ptr", stack_ptr, e);
    endtask : sp

    task automatic finish_test;
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : finish_test

    // hang guard
    initial
    begin
        #1000000;
        bad_count++;
        finish_test();
    end

    // main sequence
    initial
    begin
        {hclk, hresetn, hsel, hwrite, sp_push, sp_pop} = '0;
        {haddr, hwdata, htrans, hsize} = '0;
        port_a_in = 8'h3c;
        port_b_in = 3'b101;
        port_c_in = 8'h81;
        port_d_in = 2'b10;
        serial_port_flags = 2'b10;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        check("stack_ptr", stack_ptr, 8'hff);
        foreach (dr[i]) rc(13'h4 + i, dr[i]);
        foreach (pr[i]) rc(13'h0 + i, pr[i]);
        foreach (pw[i]) wr(13'h4 + i, 8'hff);
        foreach (pw[i]) wr(13'h0 + i, pw[i]);
        foreach (pb[i]) rc(13'h0 + i, pb[i]);
        foreach (db[i]) rc(13'h4 + i, db[i]);
        check("a_oe", port_a_oe, 8'hff);
        check("d_out", {port_d_oe, port_d_out}, 8'h03);
        check("b_pins", {port_b_oe, port_b_out}, 8'h3f);
        check("c_oe", port_c_oe, 8'hff);
        sp(1'b0, 8'hc0);
        sp(1'b1, 8'hff);
        sp(1'b1, 8'hfe);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        check("a_out", port_a_out, 8'ha5);
        check("c_out", port_c_out, 8'h5a);
        check("a_oe", port_a_oe, 8'h00);
        check("c_oe", port_c_oe, 8'h00);
        check("stack_ptr", stack_ptr, 8'hff);
        wr(13'h50, 8'h3c);
        wr(13'hff, 8'hc3);
        // port a pins have settled again by the time the first read lands
        foreach (ra[i])
        begin
            q = (rr[i] == 3'h0) ? 8'h00 : pat(ra[i]);
            if (rr[i] == 3'h1)
                q = (ra[i] == 13'h0) ? 8'h3c : 8'h00;
            if (rr[i] == 3'h3)
                q = (ra[i] == 13'h50) ? 8'h3c : 8'hc3;
            rc(ra[i], q);
            check("region", mem_region, rr[i]);
        end
        foreach (ra[i])
        begin
            xfer(1'b0, {17'h0, ra[i], 2'b00}, 8'h00, q);
            check("region", mem_region, rr[i]);
            if (rr[i] == 3'h3)
                check("ram", q, ra[i] == 13'h50 ? 8'h3c : 8'hc3);
            else if (rr[i] != 3'h1)
                check("array", q, rr[i] == 3'h0 ? 8'h00 : pat(ra[i]));
        end
        xfer(1'b0, 32'h0000_8000, 8'h00, q);
        check("far", {q[4:0], mem_region}, 8'h00);
        wr(13'h100, 8'h00);
        rc(13'h100, pat(13'h100));
        wr(13'h1ff0, 8'hfe);
        repeat (2) @(posedge hclk);
        check("wdog", wd_n[7:0], 8'h01);
        wr(13'h1ff0, 8'h01);
        repeat (2) @(posedge hclk);
        check("wdog", wd_n[7:0], 8'h01);
        rc(13'h1ff0, pat(13'h1ff0));
        wr(13'ha, 8'hff);
        rc(13'ha, 8'h50);
        check("ser", {serial_port_enable, serial_port_master}, 8'h03);
        wr(13'hb, 8'hff);
        rc(13'hb, 8'h80);
        wr(13'hc, 8'h96);
        rc(13'hc, 8'h96);
        check("ser_data", serial_port_data, 8'h96);
        check("ser_wr", sd_n[7:0], 8'h01);
        wr(13'h8, 8'hff);
        rc(13'h8, 8'h00);
        finish_test();
    end
endmodule : mmd_decoder_test
`default_nettype wire
